// ### ramp_pkg.sv
// Contract
// - The potentiometer setpoint holds with neither or both of raise and lower, rises on raise alone, falls on lower alone.
// - The potentiometer setpoint stays between the minimum and maximum frequency while raising or lowering.
// - Raising and lowering move the potentiometer setpoint at rates given by the ramp-up and ramp-down times.
// - With reverse inhibit set, lowering never takes the potentiometer setpoint below zero.
// - Setpoint retain selects whether the last setpoint is kept or the initial setpoint is loaded at start; reset clears the kept value to 0.
// - The potentiometer setpoint is presented continuously on an output.
// - A command source preset rewrites the raise and lower source selections to match that source.
// - Jog motion follows only the two jog keys, with no separate run command.
// - Each jog direction ramps toward its own configured jog frequency.
// - A single active jog key accelerates the drive to that direction's jog frequency in the jog ramp-up time;
//   the code steps at a rate that covers 0 to max_frequency in that time.
// - The jog frequency holds until the key is released, then the drive decelerates to 0 Hz in the jog ramp-down time;
//   the code steps at a rate that covers max_frequency to 0 Hz in that time.
// - Both jog keys active hold the present frequency and raise the dual-key alarm.
// - A command source preset also rewrites the two jog key source selections.
package ramp_pkg;
  // ****************************************
  // Formats and timing
  // ****************************************
  localparam int FREQ_W   = 16;   // Unsigned frequency, 0.01 Hz per count
  localparam int TIME_W   = 16;   // Ramp time in update ticks
  localparam int SRC_W    = 4;
  // Short tick period keeps a ramp test within a few thousand clocks
  localparam int TICK_US  = 10;
  localparam int CLK_MHZ  = 200;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TICK_W   = 18;
  localparam logic [FREQ_W-1:0] ZERO_FREQ = 16'h0000;

  // ****************************************
  // Command source presets and routing codes
  // ****************************************
  localparam logic [3:0] PRESET_PANEL  = 4'h1;
  localparam logic [3:0] PRESET_DIGIN  = 4'h2;
  localparam logic [3:0] PRESET_SERIAL = 4'h4;
  localparam logic [SRC_W-1:0] SRC_PANEL  = 4'h1;
  localparam logic [SRC_W-1:0] SRC_DIGIN  = 4'h2;
  localparam logic [SRC_W-1:0] SRC_SERIAL = 4'h3;

  typedef struct packed {
    logic [FREQ_W-1:0] min_frequency;
    logic [FREQ_W-1:0] max_frequency;
    logic [TIME_W-1:0] ramp_up_time;
    logic [TIME_W-1:0] ramp_down_time;
    logic              reverse_inhibit;
    logic              setpoint_retain;
    logic [FREQ_W-1:0] initial_setpoint;
  } pot_cfg_s;

  typedef struct packed {
    logic [FREQ_W-1:0] jog_right_frequency;
    logic [FREQ_W-1:0] jog_left_frequency;
    logic [TIME_W-1:0] jog_ramp_up_time;
    logic [TIME_W-1:0] jog_ramp_down_time;
  } jog_cfg_s;

  typedef struct packed {
    logic [SRC_W-1:0] raise_source_select;
    logic [SRC_W-1:0] lower_source_select;
    logic [SRC_W-1:0] jog_right_source;
    logic [SRC_W-1:0] jog_left_source;
  } route_s;

  typedef enum logic [1:0] {JOG_IDLE, JOG_RIGHT, JOG_LEFT, JOG_DUAL} jog_state_e;
endpackage : ramp_pkg

// ### ramp_step.sv
`timescale 1ns/100ps
// ****************************************
// Ramp step: max_frequency / ramp_time, at least one count
// ****************************************
module ramp_step
  import ramp_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [FREQ_W-1:0] max_frequency_i,
  input  wire logic [TIME_W-1:0] ramp_time_i,
  output logic      [FREQ_W-1:0] step_o
);
  logic [FREQ_W-1:0] next_step;

  always_comb begin
    if (ramp_time_i == '0) begin
      next_step = max_frequency_i;
    end else begin
      next_step = FREQ_W'(max_frequency_i / ramp_time_i);
    end
    if (next_step == '0) begin
      next_step = FREQ_W'(1);
    end
  end

  // Registered so the divider sits off the ramp path
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      step_o <= 16'h0001;
    end else begin
      step_o <= next_step;
    end
  end
endmodule : ramp_step

// ### setpoint_ramp_and_jog.sv
`timescale 1ns/100ps
module setpoint_ramp_and_jog
  import ramp_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              raise_i,
  input  wire logic              lower_i,
  input  wire logic              jog_right_i,
  input  wire logic              jog_left_i,
  input  wire pot_cfg_s          pot_cfg_i,
  input  wire jog_cfg_s          jog_cfg_i,
  input  wire logic              preset_write_i,
  input  wire logic [3:0]        command_source_preset_i,
  output logic      [FREQ_W-1:0] potentiometer_setpoint_out_o,
  output logic      [FREQ_W-1:0] jog_frequency_o,
  output logic                   jog_active_o,
  output logic                   dual_jog_key_alarm_o,
  output route_s                 route_o
);
  // ****************************************
  // Update tick
  // ****************************************
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic              started;
  logic [FREQ_W-1:0] retained;
  logic [FREQ_W-1:0] up_step, down_step, jup_step, jdown_step;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  ramp_step u_up (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .max_frequency_i(pot_cfg_i.max_frequency),
                  .ramp_time_i(pot_cfg_i.ramp_up_time), .step_o(up_step));
  ramp_step u_dn (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .max_frequency_i(pot_cfg_i.max_frequency),
                  .ramp_time_i(pot_cfg_i.ramp_down_time), .step_o(down_step));
  ramp_step u_jup (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .max_frequency_i(pot_cfg_i.max_frequency),
                   .ramp_time_i(jog_cfg_i.jog_ramp_up_time), .step_o(jup_step));
  ramp_step u_jdn (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .max_frequency_i(pot_cfg_i.max_frequency),
                   .ramp_time_i(jog_cfg_i.jog_ramp_down_time), .step_o(jdown_step));

  // ****************************************
  // Emulated potentiometer
  // ****************************************
  logic signed [FREQ_W+1:0] pot_up, pot_dn, lo_lim;
  logic        [FREQ_W-1:0] next_pot;

  always_comb begin
    pot_up = $signed({2'b00, potentiometer_setpoint_out_o}) + $signed({2'b00, up_step});
    pot_dn = $signed({2'b00, potentiometer_setpoint_out_o}) - $signed({2'b00, down_step});
    // Reverse inhibit floors at the larger of zero and min frequency
    lo_lim = pot_cfg_i.reverse_inhibit ? $signed({2'b00, pot_cfg_i.min_frequency}) : '0;
    next_pot = potentiometer_setpoint_out_o;
    if (tick && raise_i && !lower_i) begin
      if (pot_up > $signed({2'b00, pot_cfg_i.max_frequency})) begin
        next_pot = pot_cfg_i.max_frequency;
      end else begin
        next_pot = FREQ_W'(pot_up);
      end
    end else if (tick && lower_i && !raise_i) begin
      if (pot_dn < lo_lim || pot_dn < $signed({2'b00, pot_cfg_i.min_frequency})) begin
        next_pot = pot_cfg_i.min_frequency;
      end else begin
        next_pot = FREQ_W'(pot_dn);
      end
    end
  end

  // Setpoint is unsigned here, so lowering never crosses zero in any mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      potentiometer_setpoint_out_o <= ZERO_FREQ;
      started                      <= 1'b0;
      retained                     <= ZERO_FREQ;
    end else if (!started) begin
      started                      <= 1'b1;
      potentiometer_setpoint_out_o <= pot_cfg_i.setpoint_retain ? retained : pot_cfg_i.initial_setpoint;
    end else begin
      potentiometer_setpoint_out_o <= next_pot;
      if (pot_cfg_i.setpoint_retain) begin
        retained <= next_pot;
      end
    end
  end

  // ****************************************
  // Jog
  // ****************************************
  jog_state_e        jog_state, next_state;
  logic [FREQ_W-1:0] target, next_jog;
  logic [FREQ_W:0]   j_up, j_dn;

  always_comb begin
    case ({jog_right_i, jog_left_i})
      2'b10:   next_state = JOG_RIGHT;
      2'b01:   next_state = JOG_LEFT;
      2'b11:   next_state = JOG_DUAL;
      default: next_state = JOG_IDLE;
    endcase
  end

  always_comb begin
    case (jog_state)
      JOG_RIGHT: target = jog_cfg_i.jog_right_frequency;
      JOG_LEFT:  target = jog_cfg_i.jog_left_frequency;
      default:   target = ZERO_FREQ;
    endcase
    j_up = {1'b0, jog_frequency_o} + {1'b0, jup_step};
    j_dn = {1'b0, jog_frequency_o} - {1'b0, jdown_step};
    next_jog = jog_frequency_o;
    if (tick && jog_state != JOG_DUAL) begin
      if (jog_frequency_o < target) begin
        next_jog = (j_up > {1'b0, target}) ? target : FREQ_W'(j_up);
      end else if (jog_frequency_o > target) begin
        next_jog = (j_dn[FREQ_W] || j_dn < {1'b0, target}) ? target : FREQ_W'(j_dn);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      jog_state            <= JOG_IDLE;
      jog_frequency_o      <= ZERO_FREQ;
      jog_active_o         <= 1'b0;
      dual_jog_key_alarm_o <= 1'b0;
    end else begin
      jog_state            <= next_state;
      jog_frequency_o      <= next_jog;
      jog_active_o         <= (next_state != JOG_IDLE) || (next_jog != ZERO_FREQ);
      dual_jog_key_alarm_o <= (next_state == JOG_DUAL);
    end
  end

  // ****************************************
  // Source routing
  // ****************************************
  logic [SRC_W-1:0] preset_src;

  always_comb begin
    if (command_source_preset_i == PRESET_PANEL) begin
      preset_src = SRC_PANEL;
    end else if (command_source_preset_i == PRESET_DIGIN) begin
      preset_src = SRC_DIGIN;
    end else if (command_source_preset_i == PRESET_SERIAL) begin
      preset_src = SRC_SERIAL;
    end else begin
      preset_src = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_o <= '0;
    end else if (preset_write_i) begin
      route_o.raise_source_select <= preset_src;
      route_o.lower_source_select <= preset_src;
      route_o.jog_right_source    <= preset_src;
      route_o.jog_left_source     <= preset_src;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  pot_bounds_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    started && $past(started) && (pot_cfg_i.min_frequency <= pot_cfg_i.max_frequency) && $stable(pot_cfg_i)
    && ($past(potentiometer_setpoint_out_o) <= pot_cfg_i.max_frequency) && ($past(raise_i) || $past(lower_i))
    |-> potentiometer_setpoint_out_o <= pot_cfg_i.max_frequency)
    else $error("setpoint above maximum");
  pot_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    started && (raise_i == lower_i) |=> $stable(potentiometer_setpoint_out_o))
    else $error("setpoint moved with no single command");
  pot_idle_tick_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    started && !tick |=> $stable(potentiometer_setpoint_out_o))
    else $error("setpoint moved off tick");
  jog_dual_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    jog_state == JOG_DUAL |=> $stable(jog_frequency_o))
    else $error("jog frequency moved with both keys");
  dual_alarm_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    jog_right_i && jog_left_i |=> dual_jog_key_alarm_o)
    else $error("dual key alarm missing");
  alarm_clear_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !(jog_right_i && jog_left_i) |=> !dual_jog_key_alarm_o)
    else $error("dual key alarm stuck");
  jog_zero_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    jog_state == JOG_IDLE && tick |=> jog_frequency_o <= $past(jog_frequency_o))
    else $error("jog rose with no key");
  jog_cap_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    jog_state == JOG_RIGHT && jog_frequency_o <= jog_cfg_i.jog_right_frequency && $stable(jog_cfg_i)
    |=> jog_frequency_o <= jog_cfg_i.jog_right_frequency)
    else $error("jog overshoot");
  preset_route_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    preset_write_i && command_source_preset_i == PRESET_SERIAL
    |=> route_o.raise_source_select == SRC_SERIAL && route_o.jog_left_source == SRC_SERIAL)
    else $error("preset did not rewrite routing");
endmodule : setpoint_ramp_and_jog

// ### key_panel.sv
`timescale 1ns/100ps
// ****************************************
// Operator keys: raise, lower, jog right, jog left
// ****************************************
module key_panel (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] key_cmd_i,
  output logic            raise_o,
  output logic            lower_o,
  output logic            jog_right_o,
  output logic            jog_left_o
);
  // Keys change only just after an edge, as a panel scan would deliver them
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {raise_o, lower_o, jog_right_o, jog_left_o} <= 4'h0;
    end else begin
      {raise_o, lower_o, jog_right_o, jog_left_o} <= key_cmd_i;
    end
  end
endmodule : key_panel

// ### tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_top;
  import ramp_pkg::*;
  logic              core_clk_i;
  logic              resetn_i;
  logic [3:0]        key_cmd;
  logic              raise, lower, jog_right, jog_left;
  pot_cfg_s          pot_cfg;
  jog_cfg_s          jog_cfg;
  logic              preset_write;
  logic [3:0]        preset;
  logic [FREQ_W-1:0] setpoint, jog_freq;
  logic              jog_active, alarm;
  route_s            route;
  int                failures, comparisons, cyc;
  // ****************************************
  // Clock, partner and design
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  key_panel panel (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .key_cmd_i(key_cmd), .raise_o(raise),
                   .lower_o(lower), .jog_right_o(jog_right), .jog_left_o(jog_left));
  setpoint_ramp_and_jog dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .raise_i(raise), .lower_i(lower),
    .jog_right_i(jog_right), .jog_left_i(jog_left), .pot_cfg_i(pot_cfg), .jog_cfg_i(jog_cfg),
    .preset_write_i(preset_write), .command_source_preset_i(preset),
    .potentiometer_setpoint_out_o(setpoint), .jog_frequency_o(jog_freq), .jog_active_o(jog_active),
    .dual_jog_key_alarm_o(alarm), .route_o(route));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : wait_cyc
  task automatic report_and_stop();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // The three tick scenarios each span exactly one update tick, so the ceiling is a few tick periods
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6 * TICK_CYC) begin
      failures++;
      report_and_stop();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic check_reset();
    `CHK(setpoint, ZERO_FREQ)
    `CHK(route, 16'h0000)
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    wait_cyc(3);
    `CHK(setpoint, 16'h03E8)
    `CHK(jog_freq, ZERO_FREQ)
  endtask : check_reset
  task automatic check_presets();
    logic [3:0]       codes [4];
    logic [SRC_W-1:0] srcs  [4];
    codes = '{PRESET_PANEL, PRESET_DIGIN, PRESET_SERIAL, 4'h3};
    srcs  = '{SRC_PANEL, SRC_DIGIN, SRC_SERIAL, 4'h0};
    for (int i = 0; i < 4; i++) begin
      preset       <= codes[i];
      preset_write <= 1'b1;
      @(posedge core_clk_i);
      preset_write <= 1'b0;
      wait_cyc(2);
      `CHK(route.raise_source_select, srcs[i])
      `CHK(route.lower_source_select, srcs[i])
      `CHK(route.jog_right_source, srcs[i])
      `CHK(route.jog_left_source, srcs[i])
    end
  endtask : check_presets
  task automatic tick_raise_dual();
    key_cmd <= 4'b1011;
    wait_cyc(TICK_CYC);
    `CHK(setpoint, 16'h05DC)
    `CHK(alarm, 1'b1)
    `CHK(jog_freq, ZERO_FREQ)
  endtask : tick_raise_dual
  task automatic tick_lower_jog();
    key_cmd <= 4'b0110;
    wait_cyc(TICK_CYC);
    `CHK(setpoint, 16'h00C8)
    `CHK(alarm, 1'b0)
    `CHK(jog_freq, 16'h03E8)
    `CHK(jog_active, 1'b1)
  endtask : tick_lower_jog
  task automatic tick_both_release();
    key_cmd <= 4'b1100;
    wait_cyc(TICK_CYC);
    `CHK(setpoint, 16'h00C8)
    `CHK(jog_freq, ZERO_FREQ)
    `CHK(jog_active, 1'b0)
  endtask : tick_both_release
  task automatic retain_reset();
    pot_cfg.setpoint_retain <= 1'b1;
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    wait_cyc(2);
    resetn_i <= 1'b1;
    wait_cyc(3);
    `CHK(setpoint, ZERO_FREQ)
  endtask : retain_reset
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    failures     = 0;
    comparisons  = 0;
    cyc          = 0;
    resetn_i     = 1'b0;
    key_cmd      = 4'h0;
    preset_write = 1'b0;
    preset       = 4'h0;
    pot_cfg      = '{16'h00C8, 16'h1388, 16'h000A, 16'h0002, 1'b1, 1'b0, 16'h03E8};
    jog_cfg      = '{16'h0BB8, 16'h07D0, 16'h0005, 16'h0004};
    wait_cyc(4);
    check_reset();
    check_presets();
    wait_cyc(TICK_CYC / 2);
    tick_raise_dual();
    tick_lower_jog();
    tick_both_release();
    retain_reset();
    report_and_stop();
  end
endmodule : tb_top
